// >>> design/synth_cal_pkg.sv
/*
 * Constants and carrier types for the synthesizer calibration, RC oscillator
 * and sleep-volatile test register bank.
 * Assumes a register-access front end (the SPI slave) on the same clock,
 * which hands over one decoded read or write per request.
 */
// Functional notes
// - Band bit picks high or low VCO core
// - Five-bit VCO current, calibration result, overridable
// - Six-bit coarse tune, calibration result, overridable
// - Seven-bit calibration control, host read/write
// - Test registers lose contents through sleep
// - Code 0xBF enables temperature sensor in idle
// - Wake forces test b internally by retention
// - Test b reads its reset value after wake
// - Wake forces test a internally by retention
// - Test a reads its reset value after wake
package synth_cal_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam int          ADDR_WIDTH                  = 6;
	localparam logic [5:0]  ADDR_SYNTH_CAL_VCO_CURRENT  = 6'h24;
	localparam logic [5:0]  ADDR_SYNTH_CAL_COARSE_TUNE  = 6'h25;
	localparam logic [5:0]  ADDR_SYNTH_CAL_CONTROL      = 6'h26;
	localparam logic [5:0]  ADDR_RC_OSC_CONFIG_HIGH     = 6'h27;
	localparam logic [5:0]  ADDR_RC_OSC_CONFIG_LOW      = 6'h28;
	localparam logic [5:0]  ADDR_SYNTH_TEST_CONTROL     = 6'h29;
	localparam logic [5:0]  ADDR_PRODUCTION_TEST        = 6'h2A;
	localparam logic [5:0]  ADDR_GAIN_CONTROL_TEST      = 6'h2B;
	localparam logic [5:0]  ADDR_MISC_TEST_B            = 6'h2C;
	localparam logic [5:0]  ADDR_MISC_TEST_A            = 6'h2D;

	// ****************************************************************
	// Field positions and widths
	// ****************************************************************
	localparam int VCO_CURRENT_WIDTH  = 5;  // Bits 4:0 of 0x24
	localparam int VCO_BAND_BIT       = 5;  // Bit 5 of 0x24
	localparam int COARSE_TUNE_WIDTH  = 6;  // Bits 5:0 of 0x25
	localparam int CAL_CONTROL_WIDTH  = 7;  // Bits 6:0 of 0x26
	localparam int RC_OSC_WIDTH       = 7;  // Bits 6:0 of 0x27, 0x28
	localparam int TEST_WIDTH         = 8;  // Full byte test registers

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [0:0] RESET_VCO_BAND       = 1'h0;
	localparam logic [4:0] RESET_VCO_CURRENT    = 5'h0A;
	localparam logic [5:0] RESET_COARSE_TUNE    = 6'h20;
	localparam logic [6:0] RESET_CAL_CONTROL    = 7'h0D;
	localparam logic [6:0] RESET_RC_OSC_HIGH    = 7'h41;
	localparam logic [6:0] RESET_RC_OSC_LOW     = 7'h00;
	localparam logic [7:0] RESET_SYNTH_TEST     = 8'h59;
	localparam logic [7:0] RESET_PRODUCTION     = 8'h7F;
	localparam logic [7:0] RESET_GAIN_TEST      = 8'h3F;
	localparam logic [7:0] RESET_MISC_TEST_B    = 8'h88;
	localparam logic [7:0] RESET_MISC_TEST_A    = 8'h31;

	// ****************************************************************
	// Special codes
	// ****************************************************************
	localparam logic [7:0] TEMP_SENSOR_ENABLE   = 8'hBF;  // Production test code
	localparam logic [7:0] FORCED_TEST_B_RETAIN = 8'h81;  // Test b, retention on
	localparam logic [7:0] FORCED_TEST_A_RETAIN = 8'h35;  // Test a, retention on

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// One register request from the access front end
	typedef struct packed {
		logic                  write;  // One-cycle write strobe
		logic                  read;   // One-cycle read strobe
		logic [5:0]            addr;   // Register offset
		logic [7:0]            wdata;  // Write byte
	} reg_req_type;

	// Result handed over by the calibration engine
	typedef struct packed {
		logic                  valid;        // One-cycle load strobe
		logic [4:0]            vco_current;  // Current calibration result
		logic [5:0]            coarse_tune;  // Capacitor array result
	} cal_result_type;

endpackage

// >>> design/field_reg.sv
/*
 * One register field: host write, optional hardware load, optional loss
 * of contents on wake from sleep.
 * Assumes write, load and wake strobes are synchronous to i_mclk.
 */
`timescale 1ns/10ps
module field_reg #(
	parameter int          WIDTH    = 8,
	parameter logic [7:0]  RESET    = 8'h00,
	parameter bit          VOLATILE = 1'b0
) (
	input  wire logic              i_mclk,
	input  wire logic              i_reset_n,
	input  wire logic              i_write,      // Host write strobe
	input  wire logic [WIDTH-1:0]  i_wdata,      // Host write data
	input  wire logic              i_load,       // Hardware load strobe
	input  wire logic [WIDTH-1:0]  i_load_data,  // Hardware load data
	input  wire logic              i_wake,       // Wake from sleep pulse
	output logic      [WIDTH-1:0]  o_q           // Stored field
);

	// Field must fit in one register byte
	if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
		$error("field_reg: WIDTH must be 1 to 8");
	end

	// ****************************************************************
	// Storage
	// ****************************************************************
	// Hardware load beats host write: a result must not be lost
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_q <= RESET[WIDTH-1:0];
		end else if (VOLATILE && i_wake) begin
			o_q <= RESET[WIDTH-1:0];
		end else if (i_load) begin
			o_q <= i_load_data;
		end else if (i_write) begin
			o_q <= i_wdata;
		end
	end

endmodule

// >>> design/test_force_view.sv
/*
 * Analog-side view of a wake-forced test register. After wake the analog
 * section sees the forced value chosen by the retention setting, while the
 * register keeps its reset value for host reads.
 * Assumes wake and write strobes on i_mclk.
 */
`timescale 1ns/10ps
module test_force_view (
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_wake,        // Wake from sleep pulse
	input  wire logic        i_write,       // Host write to this register
	input  wire logic        i_retention,   // Converter retention setting
	input  wire logic [7:0]  i_reg_value,   // Host-visible register
	input  wire logic [7:0]  i_forced_on,   // Forced value, retention on
	output logic      [7:0]  o_analog       // Value the analog part uses
);

	logic forced;  // Set by wake, until the host writes

	// ****************************************************************
	// Forced flag
	// ****************************************************************
	// Wake wins over a write in the same cycle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			forced <= 1'b0;
		end else if (i_wake) begin
			forced <= 1'b1;
		end else if (i_write) begin
			forced <= 1'b0;
		end
	end

	// ****************************************************************
	// Analog value, registered
	// ****************************************************************
	// Forced value only shows here, never on the read path
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_analog <= 8'h00;
		end else if (forced && i_retention) begin
			o_analog <= i_forced_on;
		end else begin
			o_analog <= i_reg_value;
		end
	end

endmodule

// >>> design/synth_cal_register_bank.sv
/*
 * Synthesizer calibration, RC oscillator and sleep-volatile test register
 * bank of the transceiver's configuration space.
 * Assumes: the SPI slave decodes each host access into one-cycle read or
 * write strobes on i_mclk; the calibration engine, radio state machine and
 * FIFO threshold register live elsewhere on the same clock.
 */
`timescale 1ns/10ps
module synth_cal_register_bank
	import synth_cal_pkg::*;
(
	input  wire logic            i_mclk,              // 100 MHz clock
	input  wire logic            i_reset_n,           // Async reset, active low
	input  wire reg_req_type     i_req,               // Host register request
	output logic      [7:0]      o_rdata,             // Read data, registered
	output logic                 o_rvalid,            // Read data valid pulse
	input  wire cal_result_type  i_cal,               // Calibration results
	input  wire logic            i_wake,              // Leaving sleep pulse
	input  wire logic            i_radio_idle,        // Radio is in idle
	input  wire logic            i_converter_retention_setting, // Retention
	output logic                 o_vco_band_select,   // 1 = high VCO core
	output logic      [4:0]      o_vco_current,       // VCO current setting
	output logic      [5:0]      o_coarse_tune,       // VCO capacitor array
	output logic      [6:0]      o_cal_control,       // Calibration control
	output logic      [6:0]      o_rc_osc_high,       // RC oscillator config
	output logic      [6:0]      o_rc_osc_low,        // RC oscillator config
	output logic      [7:0]      o_synth_test,        // Synth test value
	output logic      [7:0]      o_gain_test,         // Gain control test
	output logic      [7:0]      o_analog_test_b,     // Test b, analog view
	output logic      [7:0]      o_analog_test_a,     // Test a, analog view
	output logic                 o_temp_sensor_en     // Temperature sensor on
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic wr_vco;      // Write to 0x24
	logic wr_coarse;   // Write to 0x25
	logic wr_control;  // Write to 0x26
	logic wr_rc_high;  // Write to 0x27
	logic wr_rc_low;   // Write to 0x28
	logic wr_synth;    // Write to 0x29
	logic wr_production_test;    // Write to 0x2A
	logic wr_gain;     // Write to 0x2B
	logic wr_test_b;   // Write to 0x2C
	logic wr_test_a;   // Write to 0x2D

	// Plain compares; a miss writes nothing
	assign wr_vco     = i_req.write && (i_req.addr == ADDR_SYNTH_CAL_VCO_CURRENT);
	assign wr_coarse  = i_req.write && (i_req.addr == ADDR_SYNTH_CAL_COARSE_TUNE);
	assign wr_control = i_req.write && (i_req.addr == ADDR_SYNTH_CAL_CONTROL);
	assign wr_rc_high = i_req.write && (i_req.addr == ADDR_RC_OSC_CONFIG_HIGH);
	assign wr_rc_low  = i_req.write && (i_req.addr == ADDR_RC_OSC_CONFIG_LOW);
	assign wr_synth   = i_req.write && (i_req.addr == ADDR_SYNTH_TEST_CONTROL);
	assign wr_production_test   = i_req.write && (i_req.addr == ADDR_PRODUCTION_TEST);
	assign wr_gain    = i_req.write && (i_req.addr == ADDR_GAIN_CONTROL_TEST);
	assign wr_test_b  = i_req.write && (i_req.addr == ADDR_MISC_TEST_B);
	assign wr_test_a  = i_req.write && (i_req.addr == ADDR_MISC_TEST_A);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [7:0] production_test;  // Production test register
	logic [7:0] misc_test_b;      // Host-visible test b
	logic [7:0] misc_test_a;      // Host-visible test a

	field_reg #(
		.WIDTH    (1),
		.RESET    ({7'h00, RESET_VCO_BAND}),
		.VOLATILE (1'b0)
	) u_vco_band (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_vco),
		.i_wdata     (i_req.wdata[VCO_BAND_BIT]),
		.i_load      (1'b0),
		.i_load_data (1'b0),
		.i_wake      (i_wake),
		.o_q         (o_vco_band_select)
	);

	field_reg #(
		.WIDTH    (VCO_CURRENT_WIDTH),
		.RESET    ({3'h0, RESET_VCO_CURRENT}),
		.VOLATILE (1'b0)
	) u_vco_current (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_vco),
		.i_wdata     (i_req.wdata[VCO_CURRENT_WIDTH-1:0]),
		.i_load      (i_cal.valid),
		.i_load_data (i_cal.vco_current),
		.i_wake      (i_wake),
		.o_q         (o_vco_current)
	);

	field_reg #(
		.WIDTH    (COARSE_TUNE_WIDTH),
		.RESET    ({2'h0, RESET_COARSE_TUNE}),
		.VOLATILE (1'b0)
	) u_coarse_tune (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_coarse),
		.i_wdata     (i_req.wdata[COARSE_TUNE_WIDTH-1:0]),
		.i_load      (i_cal.valid),
		.i_load_data (i_cal.coarse_tune),
		.i_wake      (i_wake),
		.o_q         (o_coarse_tune)
	);

	field_reg #(
		.WIDTH    (CAL_CONTROL_WIDTH),
		.RESET    ({1'h0, RESET_CAL_CONTROL}),
		.VOLATILE (1'b0)
	) u_cal_control (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_control),
		.i_wdata     (i_req.wdata[CAL_CONTROL_WIDTH-1:0]),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (o_cal_control)
	);

	field_reg #(
		.WIDTH    (RC_OSC_WIDTH),
		.RESET    ({1'h0, RESET_RC_OSC_HIGH}),
		.VOLATILE (1'b0)
	) u_rc_high (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_rc_high),
		.i_wdata     (i_req.wdata[RC_OSC_WIDTH-1:0]),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (o_rc_osc_high)
	);

	field_reg #(
		.WIDTH    (RC_OSC_WIDTH),
		.RESET    ({1'h0, RESET_RC_OSC_LOW}),
		.VOLATILE (1'b0)
	) u_rc_low (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_rc_low),
		.i_wdata     (i_req.wdata[RC_OSC_WIDTH-1:0]),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (o_rc_osc_low)
	);

	field_reg #(
		.WIDTH    (TEST_WIDTH),
		.RESET    (RESET_SYNTH_TEST),
		.VOLATILE (1'b1)
	) u_synth_test (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_synth),
		.i_wdata     (i_req.wdata),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (o_synth_test)
	);

	field_reg #(
		.WIDTH    (TEST_WIDTH),
		.RESET    (RESET_PRODUCTION),
		.VOLATILE (1'b1)
	) u_production_test (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_production_test),
		.i_wdata     (i_req.wdata),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (production_test)
	);

	field_reg #(
		.WIDTH    (TEST_WIDTH),
		.RESET    (RESET_GAIN_TEST),
		.VOLATILE (1'b1)
	) u_gain_test (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_gain),
		.i_wdata     (i_req.wdata),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (o_gain_test)
	);

	field_reg #(
		.WIDTH    (TEST_WIDTH),
		.RESET    (RESET_MISC_TEST_B),
		.VOLATILE (1'b1)
	) u_misc_test_b (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_test_b),
		.i_wdata     (i_req.wdata),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (misc_test_b)
	);

	field_reg #(
		.WIDTH    (TEST_WIDTH),
		.RESET    (RESET_MISC_TEST_A),
		.VOLATILE (1'b1)
	) u_misc_test_a (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_write     (wr_test_a),
		.i_wdata     (i_req.wdata),
		.i_load      (1'b0),
		.i_load_data ('0),
		.i_wake      (i_wake),
		.o_q         (misc_test_a)
	);

	// ****************************************************************
	// Analog views of the wake-forced test registers
	// ****************************************************************
	// test b forced by retention
	test_force_view u_view_test_b (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_wake      (i_wake),
		.i_write     (wr_test_b),
		.i_retention (i_converter_retention_setting),
		.i_reg_value (misc_test_b),
		.i_forced_on (FORCED_TEST_B_RETAIN),
		.o_analog    (o_analog_test_b)
	);

	test_force_view u_view_test_a (
		.i_mclk      (i_mclk),
		.i_reset_n   (i_reset_n),
		.i_wake      (i_wake),
		.i_write     (wr_test_a),
		.i_retention (i_converter_retention_setting),
		.i_reg_value (misc_test_a),
		.i_forced_on (FORCED_TEST_A_RETAIN),
		.o_analog    (o_analog_test_a)
	);

	// ****************************************************************
	// Temperature sensor enable
	// ****************************************************************
	// code 0xBF while idle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_temp_sensor_en <= 1'b0;
		end else begin
			o_temp_sensor_en <= (production_test == TEMP_SENSOR_ENABLE) && i_radio_idle;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [7:0] next_rdata;  // Selected read byte

	// unused bits and unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (i_req.addr)
			ADDR_SYNTH_CAL_VCO_CURRENT: begin
				next_rdata = {2'h0, o_vco_band_select, o_vco_current};
			end
			ADDR_SYNTH_CAL_COARSE_TUNE: begin
				next_rdata = {2'h0, o_coarse_tune};
			end
			ADDR_SYNTH_CAL_CONTROL: begin
				next_rdata = {1'h0, o_cal_control};
			end
			ADDR_RC_OSC_CONFIG_HIGH: begin
				next_rdata = {1'h0, o_rc_osc_high};
			end
			ADDR_RC_OSC_CONFIG_LOW: begin
				next_rdata = {1'h0, o_rc_osc_low};
			end
			ADDR_SYNTH_TEST_CONTROL: begin
				next_rdata = o_synth_test;
			end
			ADDR_PRODUCTION_TEST: begin
				next_rdata = production_test;
			end
			ADDR_GAIN_CONTROL_TEST: begin
				next_rdata = o_gain_test;
			end
			// Host view, never the forced analog value
			ADDR_MISC_TEST_B: begin
				next_rdata = misc_test_b;
			end
			ADDR_MISC_TEST_A: begin
				next_rdata = misc_test_a;
			end
			// Offsets outside this bank
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_req.read) begin
			o_rdata <= next_rdata;
		end
	end

	// One-cycle valid marks fresh read data
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.read;
		end
	end

endmodule

// >>> bench/synth_cal_register_bank_properties.sv
/*
 * Concurrent checks on the ports of the calibration register bank.
 * Assumes one clock domain and the hand-over timing of the decoded port.
 */
`timescale 1ns/10ps
module synth_cal_register_bank_properties
	import synth_cal_pkg::*;
(
	input  wire logic            i_mclk,
	input  wire logic            i_reset_n,
	input  wire reg_req_type     i_req,
	input  wire logic [7:0]      o_rdata,
	input  wire logic            o_rvalid,
	input  wire cal_result_type  i_cal,
	input  wire logic            i_wake,
	input  wire logic            i_radio_idle,
	input  wire logic            i_converter_retention_setting,
	input  wire logic            o_vco_band_select,
	input  wire logic [4:0]      o_vco_current,
	input  wire logic [5:0]      o_coarse_tune,
	input  wire logic [6:0]      o_cal_control,
	input  wire logic [7:0]      o_synth_test,
	input  wire logic [7:0]      o_gain_test,
	input  wire logic [7:0]      o_analog_test_b,
	input  wire logic [7:0]      o_analog_test_a,
	input  wire logic            o_temp_sensor_en
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	wire  wr       = i_req.write;                                 // Any write
	wire  rd_b     = i_req.read && i_req.addr == ADDR_MISC_TEST_B; // Read of test b
	wire  wr_b     = wr && i_req.addr == ADDR_MISC_TEST_B;        // Write of test b
	wire  wr_a     = wr && i_req.addr == ADDR_MISC_TEST_A;        // Write of test a
	wire  odd_addr = i_req.addr < 6'h24 || i_req.addr > 6'h2D;    // Outside the bank
	logic b_clean;  // Test b unwritten since reset or wake

	// Wake wins over a same-cycle write, so it sets the flag
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			b_clean <= 1'b1;
		else if (i_wake || wr_b)
			b_clean <= i_wake;
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	// Analog view registered from the retention level one edge earlier
	property forced_view(logic w, logic [7:0] view, logic [7:0] on, logic [7:0] off);
		i_wake ##1 !w ##1 !w |=> view == ($past(i_converter_retention_setting) ? on : off);
	endproperty

	chk_band_write:
		assert property (wr && i_req.addr == ADDR_SYNTH_CAL_VCO_CURRENT
			|=> o_vco_band_select == $past(i_req.wdata[5])) else $error("band bit wrong");
	chk_current_load:
		assert property (i_cal.valid |=> o_vco_current == $past(i_cal.vco_current))
			else $error("current load wrong");
	chk_coarse_load:
		assert property (i_cal.valid |=> o_coarse_tune == $past(i_cal.coarse_tune))
			else $error("coarse load wrong");
	chk_control_write:
		assert property (wr && i_req.addr == ADDR_SYNTH_CAL_CONTROL
			|=> o_cal_control == $past(i_req.wdata[6:0])) else $error("control wrong");
	chk_wake_restore:
		assert property (i_wake |=> o_synth_test == 8'h59 && o_gain_test == 8'h3F)
			else $error("test registers kept after wake");
	chk_test_b_forced:
		assert property (forced_view(wr_b, o_analog_test_b, 8'h81, 8'h88))
			else $error("test b analog view wrong");
	chk_test_a_forced:
		assert property (forced_view(wr_a, o_analog_test_a, 8'h35, 8'h31))
			else $error("test a analog view wrong");
	chk_test_b_read:
		assert property (b_clean && rd_b |=> o_rvalid && o_rdata == 8'h88)
			else $error("test b read wrong");
	chk_unmapped_read:
		assert property (i_req.read && odd_addr |=> o_rvalid && o_rdata == 8'h00)
			else $error("unmapped read not zero");
	chk_temp_not_idle:
		assert property (!i_radio_idle |=> !o_temp_sensor_en) else $error("sensor on outside idle");
	chk_temp_enable:
		assert property ((wr && i_req.addr == ADDR_PRODUCTION_TEST && i_req.wdata == 8'hBF
			&& !i_wake) ##1 i_radio_idle |=> o_temp_sensor_en) else $error("sensor not enabled");

	cover property (i_cal.valid);
	cover property (i_wake ##1 i_converter_retention_setting);
	cover property (o_temp_sensor_en);
endmodule

bind synth_cal_register_bank synth_cal_register_bank_properties i_props (.*);

// >>> bench/host_model.sv
/*
 * Host microcontroller model driving the bank's decoded register port.
 * Assumes requests change 1 ns after the rising edge of i_mclk.
 */
`timescale 1ns/10ps
module host_model
	import synth_cal_pkg::*;
(
	input  wire logic         i_mclk,
	input  wire logic [7:0]   i_rdata,
	input  wire logic         i_rvalid,
	output reg_req_type       o_req
);
	initial o_req = '0;

	// Released fields toggle so stale values are never trusted
	task automatic release_req();
		#1 o_req = '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
	endtask

	task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
		if (addr != ADDR_SYNTH_TEST_CONTROL && addr != ADDR_GAIN_CONTROL_TEST) begin
			@(posedge i_mclk);
			#1 o_req = '{1'b1, 1'b0, addr, data};
			@(posedge i_mclk);
			release_req();
		end
	endtask

	// Answer lands at the taking edge, so it is sampled just after it
	task automatic reg_read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
		@(posedge i_mclk);
		#1 o_req = '{1'b0, 1'b1, addr, ~o_req.wdata};
		@(posedge i_mclk);
		#1 data = i_rdata;
		ok = i_rvalid;
		o_req = '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
	endtask
endmodule

// >>> bench/synth_cal_register_bank_test.sv
/*
 * Self-checking testbench of the calibration register bank.
 * Assumes the host model drives requests and the bench the side inputs.
 */
`timescale 1ns/10ps
`define CHECK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("Error at %0t: got 0x%0h, expected 0x%0h", $time, (got), (exp)); \
		end \
	end
module synth_cal_register_bank_test;
	import synth_cal_pkg::*;
	logic            i_mclk, i_reset_n, i_wake, i_radio_idle, i_converter_retention_setting;
	reg_req_type     i_req;
	cal_result_type  i_cal;
	logic [7:0]      o_rdata, o_synth_test, o_gain_test, o_analog_test_b, o_analog_test_a;
	logic            o_rvalid, o_vco_band_select, o_temp_sensor_en, ok;
	logic [4:0]      o_vco_current;
	logic [5:0]      o_coarse_tune;
	logic [6:0]      o_cal_control, o_rc_osc_high, o_rc_osc_low;
	logic [7:0]      rd, saved_b, saved_c;  // Read byte, saved hop values
	int              fail_count, num_checks;
	localparam logic [7:0] RST [10] = '{8'h0A, 8'h20, 8'h0D, 8'h41, 8'h00,
		8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31};
	localparam logic [7:0] MASK [5] = '{8'h3F, 8'h3F, 8'h7F, 8'h7F, 8'h7F};

	synth_cal_register_bank i_dut (.*);
	host_model i_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_req(i_req));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check_read(input logic [5:0] addr, input logic [7:0] exp);
		i_host.reg_read(addr, rd, ok);
		`CHECK(ok, 1'b1)
		`CHECK(rd, exp)
	endtask
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic cal_load(input logic [4:0] cur, input logic [5:0] cap);
		@(posedge i_mclk);
		#1 i_cal = '{1'b1, cur, cap};
		@(posedge i_mclk);
		#1 i_cal = '{1'b0, ~cur, ~cap};
	endtask
	task automatic wake_pulse();
		@(posedge i_mclk);
		#1 i_wake = 1'b1;
		@(posedge i_mclk);
		#1 i_wake = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and tests
	// ****************************************************************
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// Tests need well under 1000 cycles
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		i_reset_n = 1'b0;
		i_cal = '0;
		i_wake = 1'b0;
		i_radio_idle = 1'b0;
		i_converter_retention_setting = 1'b0;
		wait_cycles(8);
		i_reset_n = 1'b1;
		for (int k = 0; k < 10; k++)
			check_read(6'(6'h24 + k), RST[k]);
		`CHECK(o_vco_band_select, 1'b0)
		$display("test reset_values done");
		// Ones into 0x24 to 0x28: unused bits must stay clear
		for (int k = 0; k < 5; k++) begin
			i_host.reg_write(6'(6'h24 + k), 8'hFF);
			check_read(6'(6'h24 + k), MASK[k]);
		end
		`CHECK({o_vco_band_select, o_vco_current, o_coarse_tune}, 12'hFFF)
		`CHECK({o_cal_control, o_rc_osc_high, o_rc_osc_low}, 21'h1F_FFFF)
		i_host.reg_write(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h15);
		`CHECK({o_vco_band_select, o_vco_current}, 6'h15)
		i_host.reg_write(6'h2E, 8'hA5);
		check_read(6'h2E, 8'h00);
		check_read(6'h23, 8'h00);
		i_host.reg_write(ADDR_SYNTH_TEST_CONTROL, 8'h00);
		`CHECK(o_synth_test, 8'h59)
		$display("test field_access done");
		// Calibrate, save, move elsewhere, then restore for the hop
		cal_load(5'h03, 6'h05);
		check_read(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h03);
		check_read(ADDR_SYNTH_CAL_COARSE_TUNE, 8'h05);
		i_host.reg_read(ADDR_SYNTH_CAL_VCO_CURRENT, saved_b, ok);
		i_host.reg_read(ADDR_SYNTH_CAL_COARSE_TUNE, saved_c, ok);
		cal_load(5'h1C, 6'h2A);
		`CHECK({o_vco_current, o_coarse_tune}, 11'h72A)
		i_host.reg_write(ADDR_SYNTH_CAL_VCO_CURRENT, saved_b);
		i_host.reg_write(ADDR_SYNTH_CAL_COARSE_TUNE, saved_c);
		`CHECK({o_vco_current, o_coarse_tune}, 11'h0C5)
		$display("test calibration_hop done");
		// Sensor code only counts while idle
		i_radio_idle = 1'b1;
		i_host.reg_write(ADDR_PRODUCTION_TEST, 8'hBF);
		wait_cycles(2);
		`CHECK(o_temp_sensor_en, 1'b1)
		i_radio_idle = 1'b0;
		wait_cycles(2);
		`CHECK(o_temp_sensor_en, 1'b0)
		i_radio_idle = 1'b1;
		i_host.reg_write(ADDR_PRODUCTION_TEST, 8'h7F);
		wait_cycles(2);
		`CHECK(o_temp_sensor_en, 1'b0)
		$display("test temp_sensor done");
		// Wake with retention on, then off
		for (int r = 1; r >= 0; r--) begin
			i_host.reg_write(ADDR_PRODUCTION_TEST, 8'h55);
			i_host.reg_write(ADDR_MISC_TEST_B, 8'h12);
			i_host.reg_write(ADDR_MISC_TEST_A, 8'h34);
			i_converter_retention_setting = r[0];
			wake_pulse();
			wait_cycles(2);
			`CHECK(o_analog_test_b, r ? 8'h81 : 8'h88)
			`CHECK(o_analog_test_a, r ? 8'h35 : 8'h31)
			check_read(ADDR_MISC_TEST_B, 8'h88);
			check_read(ADDR_MISC_TEST_A, 8'h31);
			check_read(ADDR_PRODUCTION_TEST, 8'h7F);
			check_read(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h03);
			`CHECK({o_synth_test, o_gain_test}, 16'h593F)
			i_converter_retention_setting = ~r[0];
			wait_cycles(2);
			`CHECK(o_analog_test_b, r ? 8'h88 : 8'h81)
			i_host.reg_write(ADDR_MISC_TEST_B, 8'h12);
			wait_cycles(1);
			`CHECK(o_analog_test_b, 8'h12)
		end
		$display("test wake_force done");
		report_and_stop();
	end
endmodule
